// >>> tb/sdw_gen_model.sv
// Behavioural self-test pattern generator driving the serial DAC link.
// Assumes the bench builds the frame word and holds it while go is high.
`timescale 1ns/1ps
`default_nettype none
module sdw_gen_model (
   input wire logic go_switch,
   input wire logic clock_run_switch,
   input wire logic short_mode,
   input wire logic [23:0] frame,
   input wire logic [4:0] cut_at,
   output logic link_sclk,
   output logic link_sync_n,
   output logic link_din,
   output logic standalone_test
);
   localparam time HALF = 100;
   int nbits;
   logic [23:0] shreg;
   assign standalone_test = go_switch & clock_run_switch;
   initial begin
      link_sclk = 1'b1;
      link_sync_n = 1'b1;
      link_din = 1'b0;
      forever begin
         wait (go_switch && clock_run_switch);
         shreg = frame;
         nbits = short_mode ? 16 : 24;
         link_sync_n = 1'b0;
         for (int i = 0; i <= nbits; i++) begin
            link_din = (i < nbits) ? shreg[nbits-1-i] : ~link_din;
            #HALF link_sclk = 1'b0;
            #HALF link_sclk = 1'b1;
            if (cut_at != 5'h00 && i + 1 == int'(cut_at)) break;
         end
         link_sync_n = 1'b1;
         link_din = ~link_din;
         #(6*HALF);
      end
   end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the serial DAC receiver.
// Assumes the generator model and an APB master task in this module.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, s;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic sclk, sync_n, din, upd, go, run, short_m, f1k, f100k, fhiz;
   logic [23:0] frame, f;
   logic [4:0] cut;
   logic [15:0] code;
   logic [1:0] pd, mm;
   int err_total, total_checks, cyc, nfr;
   sdw_serial_dac #(.FIFO_DEPTH(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .link_sclk(sclk), .link_sync_n(sync_n),
      .link_din(din), .dac_code(code), .pd_mode(pd), .out_pd_1k(f1k),
      .out_pd_100k(f100k), .out_hiz(fhiz), .update_pulse(upd));
   sdw_gen_model u_gen (.go_switch(go), .clock_run_switch(run), .short_mode(short_m),
      .frame(frame), .cut_at(cut), .link_sclk(sclk), .link_sync_n(sync_n), .link_din(din),
      .standalone_test());
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task end_of_test;
      if (err_total == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_of_test;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task send(input logic [4:0] c);
      @(posedge pclk);
      frame <= f;
      cut <= c;
      go <= 1'b1;
      s = 1'b0;
      for (int i = 0; i < 400 && !s; i++) begin
         @(posedge pclk);
         s = (upd === 1'b1);
      end
      go <= 1'b0;
      repeat (300) @(posedge pclk);
   endtask
   task t_regs;
      chk({code, 14'h0, pd}, 32'h0);
      apb(1'b0, sdw_pkg::SDW_OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 32'h0000_0010, 32'h0);
      chk({e, rd[30:0]}, 32'h8000_0000);
   endtask
   task t_modes;
      for (int m = 0; m < 4; m++) begin
         mm = m[1:0];
         f = {(m == 1) ? 6'h2a : 6'h00, mm, (m == 3) ? 6'h3f : 6'(m * 9 + 1), 10'h0};
         send(5'h00);
         chk(s, 1'b1);
         chk({code, 14'h0, pd}, {f[15:0], 14'h0, mm});
         chk({f1k, f100k, fhiz}, {m == 1, m == 2, m == 3});
         apb(1'b0, sdw_pkg::SDW_OFS_FIFO, 32'h0);
         chk(rd, {8'h80, f});
         nfr++;
      end
      chk(code, 16'hfc00);
      apb(1'b0, sdw_pkg::SDW_OFS_STATUS, 32'h0);
      chk(rd[17:0], {2'h3, f[15:0]});
   endtask
   task t_abort;
      f = 24'h01_2345;
      send(5'd10);
      chk(s, 1'b0);
      chk({code, 14'h0, pd}, {16'hfc00, 14'h0, 2'h3});
      apb(1'b0, sdw_pkg::SDW_OFS_FRAMES, 32'h0);
      chk(rd[15:0], 16'(nfr));
      apb(1'b0, sdw_pkg::SDW_OFS_FIFO, 32'h0);
      chk(rd[31], 1'b0);
   endtask
   task t_short;
      apb(1'b1, sdw_pkg::SDW_OFS_CTRL, 32'h1);
      apb(1'b0, sdw_pkg::SDW_OFS_CTRL, 32'h0);
      chk(rd, 32'h1);
      short_m <= 1'b1;
      f = 24'h00_eabc;
      send(5'h00);
      chk({s, code, pd}, {1'b1, 16'h0abc, 2'h2});
      apb(1'b0, sdw_pkg::SDW_OFS_FIFO, 32'h0);
      chk({rd[31], rd[15:0]}, {1'b1, f[15:0]});
      nfr++;
      short_m <= 1'b0;
      apb(1'b1, sdw_pkg::SDW_OFS_CTRL, 32'h0);
   endtask
   task t_fill;
      f = 24'h01_5400;
      @(posedge pclk);
      frame <= f;
      go <= 1'b1;
      for (int k = 0; k < 9; k++) begin
         s = 1'b0;
         for (int i = 0; i < 400 && !s; i++) begin
            @(posedge pclk);
            s = (upd === 1'b1);
         end
         chk(s, 1'b1);
         nfr++;
      end
      go <= 1'b0;
      repeat (300) @(posedge pclk);
      apb(1'b0, sdw_pkg::SDW_OFS_STATUS, 32'h0);
      chk(rd[18], 1'b1);
      apb(1'b1, sdw_pkg::SDW_OFS_STATUS, 32'h0004_0000);
      apb(1'b0, sdw_pkg::SDW_OFS_STATUS, 32'h0);
      chk(rd[18], 1'b0);
      for (int k = 0; k < 9; k++) begin
         apb(1'b0, sdw_pkg::SDW_OFS_FIFO, 32'h0);
         chk({rd[31:24], (k < 8) ? rd[23:0] : 24'h0}, (k < 8) ? {8'h80, f} : 32'h0);
      end
      apb(1'b0, sdw_pkg::SDW_OFS_FRAMES, 32'h0);
      chk(rd[15:0], 16'(nfr));
   endtask
   initial begin
      {psel, penable, pwrite, presetn, go, short_m} = 6'h00;
      paddr = 32'h0;
      pwdata = 32'h0;
      run = 1'b1;
      frame = 24'h0;
      f = 24'h0;
      cut = 5'h00;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_regs;
      t_modes;
      t_abort;
      t_short;
      t_fill;
      end_of_test;
   end
endmodule
`default_nettype wire

// >>> verilog/sdw_fifo.sv
// Small FIFO with registered read data for captured frames.
// Assumes one clock; out_ready may be combinational from the reader.
`timescale 1ns/1ps
`default_nettype none
module sdw_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   generate
      if (DEPTH < 2 || WIDTH < 1) begin : g_bad
         $error("sdw_fifo: DEPTH must be at least 2 and WIDTH at least 1");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
      logic ov;
      logic [WIDTH-1:0] od;
   } sdw_fifo_regs_t;

   sdw_fifo_regs_t q, d;
   logic push, load, full;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == LAST) ? '0 : p + AW'(1);
   endfunction

   always_comb begin
      d = q;
      // Output register counts toward depth
      full = (q.cnt + CW'(q.ov)) == FULL;
      push = in_valid && !full;
      load = (q.cnt != '0) && (!q.ov || out_ready);
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = nxt(q.wp);
      end
      if (load) begin
         d.od = q.mem[q.rp];
         d.ov = 1'b1;
         d.rp = nxt(q.rp);
      end else if (out_ready) begin
         d.ov = 1'b0;
      end
      d.cnt = q.cnt + CW'(push) - CW'(load);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign in_ready = !full;
   assign out_valid = q.ov;
   assign out_data = q.od;
endmodule
`default_nettype wire

// >>> verilog/sdw_pkg.sv
// Constants, register map and state encoding of the serial DAC receiver.
// Assumes a single APB clock domain; the serial link pins are asynchronous.
`default_nettype none
package sdw_pkg;
   // APB register byte offsets
   localparam logic [31:0] SDW_OFS_CTRL = 32'h0000_0000;
   localparam logic [31:0] SDW_OFS_STATUS = 32'h0000_0004;
   localparam logic [31:0] SDW_OFS_FIFO = 32'h0000_0008;
   localparam logic [31:0] SDW_OFS_FRAMES = 32'h0000_000c;
   // Field positions and CTRL reset value
   localparam int SDW_CTRL_VARIANT_BIT = 0;
   localparam int SDW_STAT_OVF_BIT = 18;
   localparam int SDW_FIFO_VALID_BIT = 31;
   localparam logic SDW_CTRL_RESET = 1'b0;
   // Frame geometry
   localparam int SDW_FRAME_W = 24;
   localparam logic [4:0] SDW_LAST_LONG = 5'h17;
   localparam logic [4:0] SDW_LAST_SHORT = 5'h0f;
   localparam int SDW_PD_HI_LONG = 17;
   localparam int SDW_PD_LO_LONG = 16;
   localparam int SDW_PD_HI_SHORT = 13;
   localparam int SDW_PD_LO_SHORT = 12;
   // Power-down select codes
   localparam logic [1:0] SDW_MODE_NORMAL = 2'h0;
   localparam logic [1:0] SDW_MODE_PD_1K = 2'h1;
   localparam logic [1:0] SDW_MODE_PD_100K = 2'h2;
   localparam logic [1:0] SDW_MODE_HIZ = 2'h3;
   typedef enum logic [1:0] {
      SDW_IDLE = 2'b00,
      SDW_SHIFT = 2'b01,
      SDW_DONE = 2'b10
   } sdw_state_t;
endpackage
`default_nettype wire

// >>> verilog/sdw_serial_dac.sv
// Serial-input DAC front end: frame receiver, power-down decode, APB registers.
// Assumes link pins asynchronous to pclk and a link clock well below pclk/4.
`timescale 1ns/1ps
`default_nettype none
module sdw_serial_dac #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic link_sclk,
   input wire logic link_sync_n,
   input wire logic link_din,
   output logic [15:0] dac_code,
   output logic [1:0] pd_mode,
   output logic out_pd_1k,
   output logic out_pd_100k,
   output logic out_hiz,
   output logic update_pulse
);
   localparam int FW = sdw_pkg::SDW_FRAME_W;

   generate
      if (FIFO_DEPTH < 2) begin : g_bad
         $error("sdw_serial_dac: FIFO_DEPTH must be at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [2:0] sclk_p;
      logic [1:0] sync_p;
      logic [1:0] din_p;
      sdw_pkg::sdw_state_t state;
      logic [4:0] cnt;
      logic [FW-1:0] shreg;
      logic variant;
      logic [15:0] code;
      logic [1:0] pd;
      logic pd1k;
      logic pd100k;
      logic hiz;
      logic upd;
      logic [15:0] frames;
      logic ovf;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } sdw_regs_t;

   sdw_regs_t q, d;
   logic fall, sync_hi, push, pop, acc;
   logic fifo_in_ready, fifo_out_valid;
   logic [FW-1:0] fifo_out_data;
   logic [FW-1:0] base_sh, new_sh;
   logic [4:0] base_cnt, last;

   function automatic logic mapped(input logic [31:0] a);
      mapped = (a == sdw_pkg::SDW_OFS_CTRL) || (a == sdw_pkg::SDW_OFS_STATUS) ||
               (a == sdw_pkg::SDW_OFS_FIFO) || (a == sdw_pkg::SDW_OFS_FRAMES);
   endfunction

   // Aligned second stages of the pin synchronisers
   assign fall = q.sclk_p[2] & ~q.sclk_p[1];
   assign sync_hi = q.sync_p[1];
   assign acc = psel & penable;

   always_comb begin
      d = q;
      d.sclk_p = {q.sclk_p[1:0], link_sclk};
      d.sync_p = {q.sync_p[0], link_sync_n};
      d.din_p = {q.din_p[0], link_din};
      d.upd = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      last = q.variant ? sdw_pkg::SDW_LAST_SHORT : sdw_pkg::SDW_LAST_LONG;
      base_sh = (q.state == sdw_pkg::SDW_IDLE) ? '0 : q.shreg;
      base_cnt = (q.state == sdw_pkg::SDW_IDLE) ? 5'h00 : q.cnt;
      new_sh = {base_sh[FW-2:0], q.din_p[1]};
      case (q.state)
         sdw_pkg::SDW_IDLE, sdw_pkg::SDW_SHIFT: begin
            if (sync_hi) begin
               d.state = sdw_pkg::SDW_IDLE;
               d.shreg = '0;
               d.cnt = 5'h00;
            end else begin
               d.state = sdw_pkg::SDW_SHIFT;
               d.shreg = base_sh;
               d.cnt = base_cnt;
               if (fall) begin
                  d.shreg = new_sh;
                  d.cnt = base_cnt + 5'h01;
                  if (base_cnt == last) begin
                     d.state = sdw_pkg::SDW_DONE;
                     d.upd = 1'b1;
                     push = 1'b1;
                     d.frames = q.frames + 16'h0001;
                     if (q.variant) begin
                        d.pd = {new_sh[sdw_pkg::SDW_PD_HI_SHORT],
                                new_sh[sdw_pkg::SDW_PD_LO_SHORT]};
                        d.code = {4'h0, new_sh[11:0]};
                     end else begin
                        d.pd = {new_sh[sdw_pkg::SDW_PD_HI_LONG],
                                new_sh[sdw_pkg::SDW_PD_LO_LONG]};
                        d.code = new_sh[15:0];
                     end
                  end
               end
            end
         end
         sdw_pkg::SDW_DONE: begin
            if (sync_hi) begin
               d.state = sdw_pkg::SDW_IDLE;
            end
         end
         default: begin
            d.state = sdw_pkg::SDW_IDLE;
         end
      endcase
      d.pd1k = (d.pd == sdw_pkg::SDW_MODE_PD_1K);
      d.pd100k = (d.pd == sdw_pkg::SDW_MODE_PD_100K);
      d.hiz = (d.pd == sdw_pkg::SDW_MODE_HIZ);
      // APB: one wait state, effects at the completing edge
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (acc && !q.pready) begin
         d.pready = 1'b1;
         d.pslverr = !mapped(paddr);
         d.prdata = 32'h0000_0000;
         if (paddr == sdw_pkg::SDW_OFS_CTRL) begin
            d.prdata = {31'h0, q.variant};
         end else if (paddr == sdw_pkg::SDW_OFS_STATUS) begin
            d.prdata = {11'h0, fifo_out_valid, (q.state == sdw_pkg::SDW_SHIFT),
                        q.ovf, q.pd, q.code};
         end else if (paddr == sdw_pkg::SDW_OFS_FIFO) begin
            d.prdata = {fifo_out_valid, 7'h0, fifo_out_data};
         end else if (paddr == sdw_pkg::SDW_OFS_FRAMES) begin
            d.prdata = {16'h0, q.frames};
         end
      end else if (acc && q.pready) begin
         if (pwrite && paddr == sdw_pkg::SDW_OFS_CTRL) begin
            d.variant = pwdata[sdw_pkg::SDW_CTRL_VARIANT_BIT];
         end
         if (pwrite && paddr == sdw_pkg::SDW_OFS_STATUS &&
             pwdata[sdw_pkg::SDW_STAT_OVF_BIT]) begin
            d.ovf = 1'b0;
         end
         pop = !pwrite && (paddr == sdw_pkg::SDW_OFS_FIFO) && fifo_out_valid;
      end
      // Set wins over a clear in the same cycle
      if (push && !fifo_in_ready) begin
         d.ovf = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.sclk_p <= 3'h7;
         q.sync_p <= 2'h3;
         q.variant <= sdw_pkg::SDW_CTRL_RESET;
      end else begin
         q <= d;
      end
   end

   sdw_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(push),
      .in_data(new_sh),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(pop)
   );

   assign pready = q.pready;
   assign prdata = q.prdata;
   assign pslverr = q.pslverr;
   assign dac_code = q.code;
   assign pd_mode = q.pd;
   assign out_pd_1k = q.pd1k;
   assign out_pd_100k = q.pd100k;
   assign out_hiz = q.hiz;
   assign update_pulse = q.upd;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_msb_first;
      (q.state == sdw_pkg::SDW_SHIFT && !sync_hi && fall) |=>
         q.shreg[0] == $past(q.din_p[1]) && q.shreg[FW-1:1] == $past(q.shreg[FW-2:0]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("frame bit not shifted MSB first");

   property p_long_update;
      (q.upd && !q.variant) |-> $past(fall) && $past(q.cnt) == sdw_pkg::SDW_LAST_LONG &&
         q.state == sdw_pkg::SDW_DONE;
   endproperty
   a_long_update: assert property (p_long_update) else $error("update not on 24th edge");

   property p_pd_decode;
      q.upd |-> (q.pd1k == (q.pd == 2'h1)) && (q.pd100k == (q.pd == 2'h2)) &&
         (q.hiz == (q.pd == 2'h3)) ##1 $stable(q.hiz) || q.upd;
   endproperty
   a_pd_decode: assert property (p_pd_decode) else $error("power-down decode wrong");

   property p_short_update;
      (q.upd && q.variant) |-> $past(q.cnt) == sdw_pkg::SDW_LAST_SHORT &&
         q.code[15:12] == 4'h0 &&
         q.pd == {q.shreg[13], q.shreg[12]};
   endproperty
   a_short_update: assert property (p_short_update) else $error("short frame update wrong");

   property p_abort;
      (q.state == sdw_pkg::SDW_SHIFT && sync_hi) |=>
         q.state == sdw_pkg::SDW_IDLE && q.shreg == '0 && !q.upd && $stable(q.code);
   endproperty
   a_abort: assert property (p_abort) else $error("partial frame not discarded");

   property p_ignore_top;
      (q.upd && !q.variant) |-> q.code == q.shreg[15:0] && q.pd == q.shreg[17:16];
   endproperty
   a_ignore_top: assert property (p_ignore_top) else $error("top frame bits reached output");

   property p_ready_pulse;
      q.pready |=> !q.pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held longer than one cycle");

   c_long_frame: cover property (q.upd && !q.variant && q.shreg[23:18] != 6'h00);
   c_short_frame: cover property (q.upd && q.variant);
   c_abort: cover property (q.state == sdw_pkg::SDW_SHIFT && sync_hi && q.cnt > 5'h03);
   c_overflow: cover property ($rose(q.ovf));
endmodule
`default_nettype wire
